// ---- pkg/sbrc_cfg.svh ----
// Constants for the bank, read and calibration-pattern command link
// Operation
// - Enter pattern mode: precharge, wait, set mode three
// - Pattern location zero redirects reads to pattern
// - Wait command gap and update after mode set
// - No writes while pattern mode enabled
// - Pattern read: column low zero, full burst; device chops to four when mode field is 10
// - Pattern burst appears after additive plus CAS latency
// - Controller may repeat pattern reads freely
// - Exit: wait exit delay, clear pattern enable
// - After exit, array serves; wait before activate
// - Activate opens row in bank until precharge
// - Precharge bank before activating another row
// - Precharge closes one/all banks; wait precharge period
// - Other-bank access allowed during auto precharge
// - Precharged bank idle; activate before read/write
// - Precharge to idle bank restarts precharge period
// - A12 selects chopped four or full eight
// - A12 never decoded as column bit
// - Eight beats: field 00, or 01 with A12
// - Pattern mode allows only reads until exit
// - Line 0 carries pattern; others copy or zero
`ifndef SBRC_CFG_SVH
`define SBRC_CFG_SVH
`define SBRC_AL 0
`define SBRC_CL 6
`define SBRC_RLMAX 16
`define SBRC_T_RP 9
`define SBRC_T_MRD 4
`define SBRC_T_MOD 12
`define SBRC_T_MPRR 1
`define SBRC_T_CCD 4
`define SBRC_CK_HALF 4
`define SBRC_MR_ZERO 3'h0
`define SBRC_MR_THREE 3'h3
`define SBRC_A_MPR_EN 2
`define SBRC_A_ALL 10
`define SBRC_A_BC 12
`define SBRC_OFS_CMD 4'h0
`define SBRC_OFS_STAT 4'h4
`define SBRC_OFS_RDLO 4'h8
`define SBRC_OFS_RDHI 4'hc
`define SBRC_F_OP 0
`define SBRC_F_BA 4
`define SBRC_F_ADDR 16
`endif

// ---- pkg/sbrc_pkg.sv ----
// Types shared by both ends of the command link
package sbrc_pkg;
  typedef enum logic [2:0] {
    SBRC_NOP, SBRC_MRS, SBRC_ACT, SBRC_PRE, SBRC_RD, SBRC_WR
  } sbrc_cmd_t;
endpackage

// ---- pkg/sbrc_if.sv ----
// Command, address and read data link between controller and device
interface sbrc_if;
  logic ck;
  sbrc_pkg::sbrc_cmd_t cmd;
  logic [2:0] ba;
  logic [14:0] addr;
  logic [7:0] dq;
  logic dq_vld;
  modport ctl (output ck, output cmd, output ba, output addr, input dq, input dq_vld);
  modport dev (input ck, input cmd, input ba, input addr, output dq, output dq_vld);
endinterface

// ---- rtl/sbrc_dev.sv ----
// Device end: bank state, mode registers and read burst generation
`include "sbrc_cfg.svh"
module sbrc_dev #(
  parameter int AL = `SBRC_AL,
  parameter int CL = `SBRC_CL,
  parameter int T_RP = `SBRC_T_RP,
  parameter bit DUP_DQ = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  sbrc_if.dev lnk,
  output logic mpr_on,
  output logic [7:0] bank_open,
  output logic cmd_err
);
  localparam int RLAT = AL + CL;
  localparam int RLM = `SBRC_RLMAX;

  // Two-flop synchronisers, third ck stage for edge detect
  logic [21:0] in_s1, in_s2;
  logic ck_s3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_s1 <= 22'h0;
      in_s2 <= 22'h0;
      ck_s3 <= 1'b0;
    end else begin
      in_s1 <= {lnk.ck, lnk.cmd, lnk.ba, lnk.addr};
      in_s2 <= in_s1;
      ck_s3 <= in_s2[21];
    end
  end
  wire edge_w = in_s2[21] & ~ck_s3;
  wire [2:0] cmd_w = in_s2[20:18];
  wire [2:0] ba_w = in_s2[17:15];
  wire [14:0] a_w = in_s2[14:0];
  wire is_mrs = edge_w && cmd_w == 3'(sbrc_pkg::SBRC_MRS);
  wire is_act = edge_w && cmd_w == 3'(sbrc_pkg::SBRC_ACT);
  wire is_pre = edge_w && cmd_w == 3'(sbrc_pkg::SBRC_PRE);
  wire is_rd = edge_w && cmd_w == 3'(sbrc_pkg::SBRC_RD);
  wire is_wr = edge_w && cmd_w == 3'(sbrc_pkg::SBRC_WR);

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers and bank table
  logic mpr_q;
  logic [1:0] loc_q, bl_q;
  logic [14:0] row_q [8];
  logic [7:0] open_q;
  logic [3:0] rp_q [8];
  logic [2:0] ccd_q;
  logic err_q;
  wire col_ok = ccd_q == 3'h0;
  // Burst length from mode field and A12
  wire chop_w = (bl_q == 2'b10) || (bl_q == 2'b01 && !a_w[`SBRC_A_BC]);
  wire rd_bad = !mpr_q && !open_q[ba_w];
  wire act_bad = open_q[ba_w] || rp_q[ba_w] != 4'h0;
  wire [7:0] seed_w = row_q[ba_w][7:0] ^ {a_w[9:3], 1'b0};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mpr_q <= 1'b0;
      loc_q <= 2'h0;
      bl_q <= 2'h0;
      open_q <= 8'h0;
      ccd_q <= 3'h0;
      err_q <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        row_q[i] <= 15'h0;
        rp_q[i] <= 4'h0;
      end
    end else begin
      err_q <= (is_act && act_bad) || ((is_rd || is_wr) && (rd_bad || !col_ok));
      if (edge_w && ccd_q != 3'h0)
        ccd_q <= ccd_q - 3'h1;
      if (is_rd || is_wr)
        ccd_q <= 3'(`SBRC_T_CCD - 1);
      for (int i = 0; i < 8; i++) begin
        if (edge_w && rp_q[i] != 4'h0)
          rp_q[i] <= rp_q[i] - 4'h1;
        // Precharge one or all; period restarts each time
        if (is_pre && (a_w[`SBRC_A_ALL] || ba_w == 3'(i))) begin
          open_q[i] <= 1'b0;
          rp_q[i] <= 4'(T_RP - 1);
        end
      end
      if (is_act && !act_bad) begin
        open_q[ba_w] <= 1'b1;
        row_q[ba_w] <= a_w;
      end
      if (is_mrs && ba_w == `SBRC_MR_THREE) begin
        mpr_q <= a_w[`SBRC_A_MPR_EN];
        loc_q <= a_w[1:0];
      end
      if (is_mrs && ba_w == `SBRC_MR_ZERO)
        bl_q <= a_w[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency line: {valid, pattern, chop, a2, seed}
  logic [11:0] rdl_q [RLM];
  wire [11:0] tap_w = rdl_q[RLAT - 1];
  logic [3:0] bcnt_q, blen_q;
  logic [2:0] bord_q;
  logic bmpr_q, bpat_q;
  logic [7:0] bseed_q;
  logic [7:0] dq_q;
  logic vld_q;
  wire start_w = edge_w && tap_w[11];
  wire [3:0] len_w = tap_w[9] ? 4'h4 : 4'h8;
  wire [2:0] beat_w = start_w ? {tap_w[8], 2'b00} : bord_q + bcnt_q[2:0];
  wire [7:0] s_w = start_w ? tap_w[7:0] : bseed_q;
  wire m_w = start_w ? tap_w[10] : bmpr_q;
  wire pbit_w = beat_w[0] && (start_w ? (tap_w[7:0] == 8'h0) : bpat_q);
  // Pattern bit on line 0, others copy or zero
  wire [7:0] pat_dq = DUP_DQ ? {8{pbit_w}} : {7'h0, pbit_w};
  wire more_w = edge_w && bcnt_q < blen_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < RLM; i++)
        rdl_q[i] <= 12'h0;
      bcnt_q <= 4'h0;
      blen_q <= 4'h0;
      bord_q <= 3'h0;
      bmpr_q <= 1'b0;
      bpat_q <= 1'b0;
      bseed_q <= 8'h0;
      dq_q <= 8'h0;
      vld_q <= 1'b0;
    end else begin
      if (edge_w) begin
        for (int i = 1; i < RLM; i++)
          rdl_q[i] <= rdl_q[i - 1];
        // Pattern read: seed zero marks location 00
        rdl_q[0] <= {is_rd && !rd_bad && col_ok, mpr_q, chop_w, a_w[2],
                     mpr_q ? {7'h0, loc_q != 2'h0} : seed_w};
      end
      if (start_w) begin
        bcnt_q <= 4'h1;
        blen_q <= len_w;
        bord_q <= {tap_w[8], 2'b00};
        bmpr_q <= tap_w[10];
        bpat_q <= tap_w[7:0] == 8'h0;
        bseed_q <= tap_w[7:0];
      end else if (more_w)
        bcnt_q <= bcnt_q + 4'h1;
      if (start_w || more_w) begin
        vld_q <= 1'b1;
        dq_q <= m_w ? pat_dq : s_w + {5'h0, beat_w};
      end else if (edge_w)
        vld_q <= 1'b0;
    end
  end

  assign lnk.dq = dq_q;
  assign lnk.dq_vld = vld_q;
  assign mpr_on = mpr_q;
  assign bank_open = open_q;
  assign cmd_err = err_q;
endmodule

// ---- rtl/sbrc_ctl.sv ----
// Controller end: AHB-Lite registers, link clock and command checks
`include "sbrc_cfg.svh"
module sbrc_ctl #(
  parameter int AL = `SBRC_AL,
  parameter int CL = `SBRC_CL,
  parameter int T_RP = `SBRC_T_RP,
  parameter int T_MRD = `SBRC_T_MRD,
  parameter int T_MOD = `SBRC_T_MOD,
  parameter int T_MPRR = `SBRC_T_MPRR,
  parameter int CK_HALF = `SBRC_CK_HALF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  sbrc_if.ctl lnk
);
  localparam int RLAT = AL + CL;
  localparam int T_MW = T_MRD > T_MOD ? T_MRD : T_MOD;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  logic aw_q, ar_q;
  logic [3:0] aofs_q;
  wire take_w = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_q <= 1'b0;
      ar_q <= 1'b0;
      aofs_q <= 4'h0;
    end else begin
      aw_q <= take_w && hwrite;
      ar_q <= take_w && !hwrite;
      aofs_q <= haddr[3:0];
    end
  end
  wire wr_cmd = aw_q && aofs_q == `SBRC_OFS_CMD;
  wire wr_stat = aw_q && aofs_q == `SBRC_OFS_STAT;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider; commands change while ck is low
  logic [7:0] div_q;
  logic ck_q;
  wire wrap_w = div_q == 8'(CK_HALF - 1);
  wire fall_w = wrap_w && ck_q;
  wire rise_w = wrap_w && !ck_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h0;
      ck_q <= 1'b0;
    end else begin
      div_q <= wrap_w ? 8'h0 : div_q + 8'h1;
      if (wrap_w)
        ck_q <= !ck_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending order from the command register
  logic pend_q;
  logic [2:0] op_q, ba_q;
  logic [14:0] a_q;
  wire sbrc_pkg::sbrc_cmd_t op_w = sbrc_pkg::sbrc_cmd_t'(op_q);

  // Bank table and timers, all counted in link clock periods
  logic [7:0] open_q;
  logic [14:0] row_q [8];
  logic [3:0] rp_q [8];
  logic [4:0] mw_q, ccd_q;
  logic [5:0] quiet_q;
  logic mpr_q, err_q, rdone_q;
  logic [1:0] bl_q;
  wire all_idle = open_q == 8'h0 && rp_q[0] == 4'h0 && rp_q[1] == 4'h0 &&
                  rp_q[2] == 4'h0 && rp_q[3] == 4'h0 && rp_q[4] == 4'h0 &&
                  rp_q[5] == 4'h0 && rp_q[6] == 4'h0 && rp_q[7] == 4'h0;
  wire mr3_w = ba_q == `SBRC_MR_THREE;
  wire en_mpr = a_q[`SBRC_A_MPR_EN];
  // Mode set: banks idle, gap met, reads drained before exit
  wire ok_mrs = mw_q == 5'h0 && (mpr_q ? (mr3_w && !en_mpr && quiet_q == 6'h0)
                : all_idle);
  wire ok_act = !mpr_q && mw_q == 5'h0 && !open_q[ba_q] &&
                rp_q[ba_q] == 4'h0;
  wire ok_pre = !mpr_q && mw_q == 5'h0;
  // Reads outside pattern mode need only their own bank open; other banks may be precharging
  wire ok_rd = mw_q == 5'h0 && ccd_q == 5'h0 &&
               (mpr_q || open_q[ba_q]);
  wire ok_wr = !mpr_q && mw_q == 5'h0 && ccd_q == 5'h0 && open_q[ba_q];
  logic ok_w;
  always_comb begin
    case (op_w)
      sbrc_pkg::SBRC_MRS: ok_w = ok_mrs;
      sbrc_pkg::SBRC_ACT: ok_w = ok_act;
      sbrc_pkg::SBRC_PRE: ok_w = ok_pre;
      sbrc_pkg::SBRC_RD: ok_w = ok_rd;
      sbrc_pkg::SBRC_WR: ok_w = ok_wr;
      sbrc_pkg::SBRC_NOP: ok_w = 1'b1;
      default: ok_w = 1'b0;
    endcase
  end
  wire issue_w = fall_w && pend_q && ok_w;
  wire refuse_w = fall_w && pend_q && !ok_w;
  wire is_rd = issue_w && op_w == sbrc_pkg::SBRC_RD;
  wire is_pre = issue_w && op_w == sbrc_pkg::SBRC_PRE;
  wire chop_w = bl_q == 2'b10 || (bl_q == 2'b01 && !a_q[`SBRC_A_BC]);
  // Pattern reads force column 000 and A12 high, a full burst unless the mode field is 10
  wire [14:0] a_out = (is_rd && mpr_q) ? {2'b00, 1'b1, a_q[11:3], 3'b000} : a_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, one link clock period per command
  sbrc_pkg::sbrc_cmd_t cmd_q;
  logic [2:0] pba_q;
  logic [14:0] pa_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= sbrc_pkg::SBRC_NOP;
      pba_q <= 3'h0;
      pa_q <= 15'h0;
    end else if (fall_w) begin
      cmd_q <= issue_w ? op_w : sbrc_pkg::SBRC_NOP;
      pba_q <= ba_q;
      pa_q <= a_out;
    end
  end
  assign lnk.ck = ck_q;
  assign lnk.cmd = cmd_q;
  assign lnk.ba = pba_q;
  assign lnk.addr = pa_q;

  ////////////////////////////////////////////////////////////////////////////
  // Order intake, bank tracking and timers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      op_q <= 3'h0;
      ba_q <= 3'h0;
      a_q <= 15'h0;
      open_q <= 8'h0;
      mw_q <= 5'h0;
      ccd_q <= 5'h0;
      quiet_q <= 6'h0;
      mpr_q <= 1'b0;
      bl_q <= 2'h0;
      err_q <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        row_q[i] <= 15'h0;
        rp_q[i] <= 4'h0;
      end
    end else begin
      if (wr_cmd && !pend_q) begin
        pend_q <= 1'b1;
        op_q <= hwdata[`SBRC_F_OP +: 3];
        ba_q <= hwdata[`SBRC_F_BA +: 3];
        a_q <= hwdata[`SBRC_F_ADDR +: 15];
      end else if (fall_w)
        pend_q <= 1'b0;
      // Refusal or busy write sets error; set beats clear
      if (refuse_w || (wr_cmd && pend_q))
        err_q <= 1'b1;
      else if (wr_stat && hwdata[1])
        err_q <= 1'b0;
      if (fall_w) begin
        if (mw_q != 5'h0)
          mw_q <= mw_q - 5'h1;
        if (ccd_q != 5'h0)
          ccd_q <= ccd_q - 5'h1;
        if (quiet_q != 6'h0)
          quiet_q <= quiet_q - 6'h1;
        for (int i = 0; i < 8; i++)
          if (rp_q[i] != 4'h0)
            rp_q[i] <= rp_q[i] - 4'h1;
      end
      if (issue_w && op_w == sbrc_pkg::SBRC_MRS) begin
        mw_q <= 5'(T_MW);
        if (mr3_w)
          mpr_q <= en_mpr;
        if (ba_q == `SBRC_MR_ZERO)
          bl_q <= a_q[1:0];
      end
      if (issue_w && op_w == sbrc_pkg::SBRC_ACT) begin
        open_q[ba_q] <= 1'b1;
        row_q[ba_q] <= a_q;
      end
      for (int i = 0; i < 8; i++)
        if (is_pre && (a_q[`SBRC_A_ALL] || ba_q == 3'(i))) begin
          open_q[i] <= 1'b0;
          rp_q[i] <= 4'(T_RP);
        end
      if (is_rd || (issue_w && op_w == sbrc_pkg::SBRC_WR))
        // Full burst holds the data lines eight link periods
        ccd_q <= (mpr_q || !chop_w) ? 5'(2 * `SBRC_T_CCD - 1) :
                 5'(`SBRC_T_CCD - 1);
      // Exit waits for last burst end plus exit delay
      if (is_rd)
        quiet_q <= 6'(RLAT + 8 + T_MPRR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture: synchronise, sample on each ck rise
  logic [8:0] dq_s1, dq_s2;
  logic vld_l;
  logic [63:0] shf_q, rd_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_s1 <= 9'h0;
      dq_s2 <= 9'h0;
      vld_l <= 1'b0;
      shf_q <= 64'h0;
      rd_q <= 64'h0;
      rdone_q <= 1'b0;
    end else begin
      dq_s1 <= {lnk.dq_vld, lnk.dq};
      dq_s2 <= dq_s1;
      if (rise_w) begin
        vld_l <= dq_s2[8];
        if (dq_s2[8])
          shf_q <= {dq_s2[7:0], shf_q[63:8]};
      end
      if (rise_w && vld_l && !dq_s2[8]) begin
        rd_q <= shf_q;
        rdone_q <= 1'b1;
      end else if (wr_stat && hwdata[2])
        rdone_q <= 1'b0;
    end
  end

  // Read mux from registered address phase
  wire [31:0] stat_w = {16'h0, open_q, bl_q, 1'b0, quiet_q != 6'h0, pend_q, mpr_q, rdone_q,
                        err_q};
  assign hrdata = !ar_q ? 32'h0 :
                  aofs_q == `SBRC_OFS_STAT ? stat_w :
                  aofs_q == `SBRC_OFS_RDLO ? rd_q[31:0] :
                  aofs_q == `SBRC_OFS_RDHI ? rd_q[63:32] : 32'h0;
endmodule

// ---- tb/sbrc_link_monitor.sv ----
// Protocol checks on the command link between controller and device
module sbrc_link_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ck,
  input sbrc_pkg::sbrc_cmd_t cmd,
  input wire logic [2:0] ba,
  input wire logic [14:0] addr,
  input wire logic [7:0] dq,
  input wire logic dq_vld
);
  logic mpr_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Pattern mode as last ordered on the link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mpr_q <= 1'b0;
    end else if ($fell(ck) && cmd == sbrc_pkg::SBRC_MRS && ba == 3'h3) begin
      mpr_q <= addr[2];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Link clock halves, command launch and hold
  ck_high_len_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
    else $error("link clock high phase wrong");
  ck_low_len_a: assert property ($fell(ck) |-> !ck [*4] ##1 ck)
    else $error("link clock low phase wrong");
  cmd_on_fall_a: assert property ($changed(cmd) |-> $fell(ck))
    else $error("command changed off the clock fall");
  cmd_hold_a: assert property ($fell(ck) && cmd != sbrc_pkg::SBRC_NOP
    |=> $stable(cmd) [*7])
    else $error("command not held one link period");
  // Pattern mode command limits
  mpr_rd_addr_a: assert property ($fell(ck) && mpr_q && cmd == sbrc_pkg::SBRC_RD
    |-> addr[2:0] == 3'h0 && addr[12])
    else $error("pattern read address wrong");
  mpr_only_rd_a: assert property ($fell(ck) && mpr_q
    && cmd != sbrc_pkg::SBRC_NOP |-> cmd inside {sbrc_pkg::SBRC_RD, sbrc_pkg::SBRC_MRS})
    else $error("forbidden command in pattern mode");
  // Read data timing and content
  read_lat_a: assert property ($fell(ck) && cmd == sbrc_pkg::SBRC_RD
    |-> ##[48:64] dq_vld)
    else $error("read data late");
  beat_len_a: assert property ($rose(dq_vld) |-> dq_vld [*8])
    else $error("beat shorter than a link period");
  mpr_pattern_a: assert property (mpr_q && $rose(dq_vld)
    |-> dq == 8'h00 ##8 dq == 8'hff)
    else $error("pattern burst wrong");
  mpr_dq_copy_a: assert property (mpr_q && dq_vld |-> dq[7:1] == {7{dq[0]}})
    else $error("pattern lines differ");
endmodule

// ---- tb/sbrc_tb_top.sv ----
// Bench joining controller and device, driven over AHB-Lite
`include "sbrc_cfg.svh"
module sbrc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    sbrc_pkg::sbrc_cmd_t op;
    logic [2:0] ba;
    logic [14:0] a;
    logic [9:0] st;
    logic [31:0] lo;
    logic [31:0] hi;
  } sbrc_row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mpr_on, cmd_err;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] bank_open;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int err_pulses = 0;
  sbrc_row_t rows[17];
  assign hready = hreadyout;
  sbrc_if lnk_if ();
  sbrc_ctl i_sbrc_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk_if.ctl));
  sbrc_dev i_sbrc_dev (.hclk(hclk), .hresetn(hresetn), .lnk(lnk_if.dev), .mpr_on(mpr_on),
    .bank_open(bank_open), .cmd_err(cmd_err));
  sbrc_link_monitor i_sbrc_link_monitor (.hclk(hclk), .hresetn(hresetn), .ck(lnk_if.ck),
    .cmd(lnk_if.cmd), .ba(lnk_if.ba), .addr(lnk_if.addr), .dq(lnk_if.dq), .dq_vld(lnk_if.dq_vld));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, device error pulses and hang guard
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cmd_err === 1'b1) err_pulses++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask
  // One single AHB-Lite word transfer
  task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Clear error, issue one order, wait until idle and settled
  task automatic order(input sbrc_row_t r);
    int n;
    ahb(1'b1, 32'h4, 32'h2);
    ahb(1'b1, 32'h0, {1'b0, r.a, 9'h0, r.ba, 1'b0, r.op});
    n = 0;
    do begin
      ahb(1'b0, 32'h4, 32'h0);
      n++;
    end while (rd[4:3] !== 2'b00 && n < 200);
    chk("order settled", {30'h0, rd[4:3]}, 32'h0);
    repeat ((`SBRC_T_MOD + 2) * 8) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rows = '{
      '{sbrc_pkg::SBRC_MRS, 3'h0, 15'h0001, 10'h000, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_ACT, 3'h1, 15'h0123, 10'h008, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_RD, 3'h1, 15'h1010, 10'h008, 32'h2a292827, 32'h2e2d2c2b},
      '{sbrc_pkg::SBRC_RD, 3'h1, 15'h0010, 10'h008, 32'h2e2d2c2b, 32'h2a292827},
      '{sbrc_pkg::SBRC_ACT, 3'h1, 15'h0077, 10'h009, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_RD, 3'h2, 15'h1000, 10'h009, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_PRE, 3'h1, 15'h0000, 10'h000, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_PRE, 3'h1, 15'h0000, 10'h000, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_ACT, 3'h0, 15'h0005, 10'h004, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_ACT, 3'h3, 15'h0006, 10'h024, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_PRE, 3'h0, 15'h0400, 10'h000, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_MRS, 3'h3, 15'h0004, 10'h002, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_WR, 3'h0, 15'h0000, 10'h003, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_ACT, 3'h2, 15'h0000, 10'h003, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_RD, 3'h5, 15'h1007, 10'h002, 32'hff00ff00, 32'hff00ff00},
      '{sbrc_pkg::SBRC_MRS, 3'h3, 15'h0000, 10'h000, 32'h0, 32'h0},
      '{sbrc_pkg::SBRC_ACT, 3'h2, 15'h0010, 10'h010, 32'h0, 32'h0}};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped read", rd, 32'h0);
    chk("response", {31'h0, hresp}, 32'h0);
    foreach (rows[i]) begin
      order(rows[i]);
      chk("status", {22'h0, rd[15:8], rd[2], rd[0]}, {22'h0, rows[i].st});
      chk("device state", {23'h0, bank_open, mpr_on}, {23'h0, rows[i].st[9:1]});
      if (rows[i].op == sbrc_pkg::SBRC_RD && !rows[i].st[0]) begin
        ahb(1'b0, 32'h8, 32'h0);
        chk("read low", rd, rows[i].lo);
        ahb(1'b0, 32'hc, 32'h0);
        chk("read high", rd, rows[i].hi);
      end
    end
    chk("device errors", err_pulses, 32'h0);
    // Reset in mid-run with a bank open
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("reset state", {22'h0, bank_open, mpr_on, lnk_if.dq_vld}, 32'h0);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h4, 32'h0);
    chk("status after reset", rd, 32'h0);
    finish_test();
  end
endmodule
